// [inc/prom_consts.svh]
// Offsets, field positions, reset values and timing counts of the EEPROM command block.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef PROM_CONSTS_SVH
`define PROM_CONSTS_SVH
// ****************************************
// Register map
// ****************************************
`define CMD_OFFSET      8'hB0
`define DATA_OFFSET     8'hB4
`define ISTAT_OFFSET    8'hB8
`define ICLR_OFFSET     8'hBC
`define IEN_OFFSET      8'hC0
`define CMD_BUSY_BIT    31
`define CMD_OP_MSB      30
`define CMD_OP_LSB      28
`define CMD_TMO_BIT     9
`define IRQ_DONE_BIT    0
`define IRQ_TMO_BIT     1
`define OP_WRITE        3'h1
`define BUSY_RESET      1'b1
`define HREADY_RESET    1'b1
// ****************************************
// Serial link and timing
// ****************************************
`define INSTR_READ      8'h03
`define INSTR_WRITE     8'h02
`define FRAME_BITS      5'h18
`define MAC_BYTES       6
`define CLK_MHZ         50
`define TIMEOUT_US      30000
`define TIMEOUT_CYCLES  (`TIMEOUT_US * `CLK_MHZ)
`define SCK_HALF_NS     1000
`define SCK_HALF_CYCLES ((`SCK_HALF_NS * `CLK_MHZ + 999) / 1000)
`endif

// [inc/prom_pkg.sv]
// Types shared by the EEPROM command block and its serial engine.
// Assumes nothing beyond a SystemVerilog compiler.
package prom_pkg;
    typedef enum logic [1:0] {ENG_IDLE, ENG_SHIFT, ENG_WAIT} eng_mode_t;

    typedef struct packed {
        logic       valid;
        logic       is_write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } prom_req_t;

    typedef struct packed {
        logic       done;
        logic       timed_out;
        logic [7:0] rdata;
    } prom_rsp_t;

    typedef struct packed {
        logic cs;
        logic sck;
        logic dout;
    } prom_pins_t;

    typedef struct packed {
        eng_mode_t   mode;
        logic        is_write;
        logic [7:0]  half;
        logic [4:0]  cnt;
        logic [23:0] shreg;
        logic        cap;
        logic [31:0] wait_cnt;
        logic        di_meta;
        logic        di_sync;
        prom_rsp_t   rsp;
        prom_pins_t  pins;
    } eng_state_t;

    typedef struct packed {
        logic        dp_valid;
        logic        dp_write;
        logic [7:0]  dp_addr;
        logic        busy;
        logic [2:0]  op;
        logic [7:0]  addr;
        logic [7:0]  data;
        logic        timeout;
        logic        boot;
        logic [2:0]  idx;
        logic [47:0] mac;
        prom_req_t   req;
        logic [1:0]  istat;
        logic [1:0]  ien;
        logic        irq;
        logic        hreadyout;
        logic [31:0] hrdata;
    } top_state_t;
endpackage

// [logic/prom_serial_engine.sv]
// Serial engine: shifts one 24-bit frame to the EEPROM and polls ready after writes.
// Assumes requests arrive only while idle; prom_di comes from a pin.
`timescale 1ns/1ps
`include "prom_consts.svh"
module prom_serial_engine #(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
    parameter int unsigned SCK_HALF       = `SCK_HALF_CYCLES
) (
    input  wire logic          core_clk,
    input  wire logic          reset,
    input  prom_pkg::prom_req_t  req,
    output prom_pkg::prom_rsp_t  rsp,
    output prom_pkg::prom_pins_t pins,
    input  wire logic          prom_di
);
    import prom_pkg::*;

    eng_state_t s;
    eng_state_t next_s;

    // ****************************************
    // Frame sequencing
    // ****************************************
    // Data changes on the falling edge, sampled on the rising edge
    always_comb begin
        next_s = s;
        next_s.di_meta = prom_di;
        next_s.di_sync = s.di_meta;
        next_s.rsp.done = 1'b0;
        next_s.rsp.timed_out = 1'b0;
        case (s.mode)
            ENG_IDLE: begin
                if (req.valid) begin
                    next_s.mode = ENG_SHIFT;
                    next_s.is_write = req.is_write;
                    next_s.shreg = {req.is_write ? `INSTR_WRITE : `INSTR_READ,
                                    req.addr, req.wdata};
                    next_s.pins.cs = 1'b1;
                    next_s.pins.dout = next_s.shreg[23];
                    next_s.cnt = `FRAME_BITS;
                    next_s.half = 8'h00;
                    next_s.wait_cnt = 32'h0;
                end
            end
            ENG_SHIFT: begin
                if (s.half == 8'(SCK_HALF - 1)) begin
                    next_s.half = 8'h00;
                    if (!s.pins.sck) begin
                        next_s.pins.sck = 1'b1;
                        next_s.cap = s.di_sync;
                    end else begin
                        next_s.pins.sck = 1'b0;
                        next_s.shreg = {s.shreg[22:0], s.cap};
                        next_s.pins.dout = s.shreg[22];
                        next_s.cnt = s.cnt - 5'h01;
                        if (s.cnt == 5'h01) begin
                            if (s.is_write) begin
                                next_s.mode = ENG_WAIT;
                            end else begin
                                next_s.mode = ENG_IDLE;
                                next_s.pins.cs = 1'b0;
                                next_s.rsp.done = 1'b1;
                                next_s.rsp.rdata = {s.shreg[6:0], s.cap};
                            end
                        end
                    end
                end else begin
                    next_s.half = s.half + 8'h01;
                end
            end
            ENG_WAIT: begin
                // An absent part never raises ready, so the count ends the wait
                next_s.wait_cnt = s.wait_cnt + 32'h1;
                if (s.di_sync || s.wait_cnt == TIMEOUT_CYCLES - 1) begin
                    next_s.mode = ENG_IDLE;
                    next_s.pins.cs = 1'b0;
                    next_s.rsp.done = 1'b1;
                    next_s.rsp.timed_out = !s.di_sync;
                end
            end
            default: next_s.mode = ENG_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rsp = s.rsp;
    assign pins = s.pins;
endmodule // prom_serial_engine

// [logic/eeprom_command_control.sv]
// EEPROM command and status block with an AHB-Lite register slave.
// Assumes one AHB-Lite master, word transfers only, and one serial EEPROM.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "prom_consts.svh"
module eeprom_command_control #(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
    parameter int unsigned SCK_HALF       = `SCK_HALF_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             prom_cs,
    output logic             prom_sck,
    output logic             prom_do,
    input  wire logic        prom_di,
    output logic      [47:0] mac_addr,
    output logic             irq
);
    import prom_pkg::*;

    top_state_t s;
    top_state_t next_s;
    prom_rsp_t  eng_rsp;
    prom_pins_t eng_pins;
    logic       addr_phase;
    logic [1:0] clr;
    logic [1:0] ev;

    // ****************************************
    // Serial engine
    // ****************************************
    prom_serial_engine #(
        .TIMEOUT_CYCLES (TIMEOUT_CYCLES),
        .SCK_HALF       (SCK_HALF)
    ) u_engine (
        .core_clk (core_clk),
        .reset    (reset),
        .req      (s.req),
        .rsp      (eng_rsp),
        .pins     (eng_pins),
        .prom_di  (prom_di)
    );

    // ****************************************
    // Register file and command control
    // ****************************************
    // Reads are prepared in the address phase so hrdata is a flop in the data phase
    always_comb begin
        next_s = s;
        clr = 2'h0;
        ev = 2'h0;
        next_s.req.valid = 1'b0;
        next_s.hreadyout = 1'b1;
        addr_phase = hsel && htrans[1] && hready;
        next_s.dp_valid = addr_phase;
        next_s.dp_write = hwrite;
        next_s.dp_addr = haddr[7:0];
        if (addr_phase && !hwrite) begin
            if (haddr[7:0] == `CMD_OFFSET) begin
                next_s.hrdata = {s.busy, s.op, 18'h0, s.timeout, 1'b0, s.addr};
            end else if (haddr[7:0] == `DATA_OFFSET) begin
                next_s.hrdata = {24'h0, s.data};
            end else if (haddr[7:0] == `ISTAT_OFFSET) begin
                next_s.hrdata = {30'h0, s.istat};
            end else if (haddr[7:0] == `IEN_OFFSET) begin
                next_s.hrdata = {30'h0, s.ien};
            end else begin
                next_s.hrdata = 32'h0;
            end
        end
        // Writes land in the data phase; a busy controller ignores both registers
        if (s.dp_valid && s.dp_write) begin
            if (s.dp_addr == `CMD_OFFSET) begin
                if (hwdata[`CMD_BUSY_BIT] && !s.busy) begin
                    next_s.busy = 1'b1;
                    next_s.op = hwdata[`CMD_OP_MSB:`CMD_OP_LSB];
                    next_s.addr = hwdata[7:0];
                    next_s.timeout = 1'b0;
                    next_s.req.valid = 1'b1;
                    next_s.req.is_write = hwdata[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_WRITE;
                    next_s.req.addr = hwdata[7:0];
                    next_s.req.wdata = s.data;
                end
            end else if (s.dp_addr == `DATA_OFFSET) begin
                if (!s.busy) begin
                    next_s.data = hwdata[7:0];
                end
            end else if (s.dp_addr == `ICLR_OFFSET) begin
                clr = hwdata[1:0];
            end else if (s.dp_addr == `IEN_OFFSET) begin
                next_s.ien = hwdata[1:0];
            end
        end
        // Completion: the boot load walks the MAC bytes, host ops end busy
        if (eng_rsp.done) begin
            if (s.boot) begin
                next_s.mac[s.idx * 8 +: 8] = eng_rsp.rdata;
                if (s.idx == 3'(`MAC_BYTES - 1)) begin
                    next_s.boot = 1'b0;
                    next_s.busy = 1'b0;
                end else begin
                    next_s.idx = s.idx + 3'h1;
                    next_s.req.valid = 1'b1;
                    next_s.req.is_write = 1'b0;
                    next_s.req.addr = {5'h0, s.idx + 3'h1};
                end
            end else begin
                next_s.busy = 1'b0;
                next_s.timeout = eng_rsp.timed_out;
                if (s.op != `OP_WRITE) begin
                    next_s.data = eng_rsp.rdata;
                end
                ev[`IRQ_DONE_BIT] = 1'b1;
                ev[`IRQ_TMO_BIT] = eng_rsp.timed_out;
            end
        end
        // Sticky status: a new event outweighs a clear in the same cycle
        next_s.istat = (s.istat & ~clr) | ev;
        next_s.irq = |(next_s.istat & next_s.ien);
    end

    // ****************************************
    // State register
    // ****************************************
    // State register; reset starts the MAC load with busy already set
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
            s.busy <= `BUSY_RESET;
            s.boot <= 1'b1;
            s.req.valid <= 1'b1;
            s.hreadyout <= `HREADY_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Outputs straight from flops; hresp is tied low
    assign hrdata = s.hrdata;
    assign hreadyout = s.hreadyout;
    assign hresp = 1'b0;
    assign prom_cs = eng_pins.cs;
    assign prom_sck = eng_pins.sck;
    assign prom_do = eng_pins.dout;
    assign mac_addr = s.mac;
    assign irq = s.irq;

    // ****************************************
    // Checks
    // ****************************************
    // A write data phase aimed at the command register
    logic cmd_wr;
    assign cmd_wr = s.dp_valid && s.dp_write && s.dp_addr == `CMD_OFFSET;

    start_on_set_a: assert property (@(posedge core_clk) disable iff (reset)
        cmd_wr && hwdata[31] && !s.busy |=> s.busy && s.req.valid
            && s.req.addr == $past(hwdata[7:0]))
        else $error("set busy did not start an operation");
    busy_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        s.busy && !eng_rsp.done |=> s.busy)
        else $error("busy dropped before completion");
    busy_clear_a: assert property (@(posedge core_clk) disable iff (reset)
        eng_rsp.done && !s.boot |=> !s.busy ##1 !s.busy)
        else $error("busy not cleared after completion");
    read_data_a: assert property (@(posedge core_clk) disable iff (reset)
        eng_rsp.done && !s.boot && s.op != `OP_WRITE |=> s.data == $past(eng_rsp.rdata))
        else $error("read data not captured");
    timeout_clear_a: assert property (@(posedge core_clk) disable iff (reset)
        eng_rsp.timed_out && !s.boot |=> !s.busy && s.timeout && s.istat[1])
        else $error("time-out did not clear busy");
    boot_busy_a: assert property (@(posedge core_clk) disable iff (reset)
        s.boot |-> s.busy)
        else $error("busy low during MAC load");
    boot_end_a: assert property (@(posedge core_clk) disable iff (reset)
        $fell(s.boot) |-> !s.busy && $past(eng_rsp.done))
        else $error("MAC load ended wrongly");
    zero_write_a: assert property (@(posedge core_clk) disable iff (reset)
        cmd_wr && !hwdata[31] && !eng_rsp.done |=> s.busy == $past(s.busy) && !s.req.valid)
        else $error("zero write changed busy");

    // Select only inside an operation, zero wait states, refusals while busy, sticky done status
    cs_in_op_a: assert property (@(posedge core_clk) disable iff (reset)
        prom_cs |-> s.busy)
        else $error("select high while not busy");
    ready_always_a: assert property (@(posedge core_clk) disable iff (reset)
        hreadyout)
        else $error("wait state inserted");
    busy_refuse_a: assert property (@(posedge core_clk) disable iff (reset)
        cmd_wr && s.busy && !eng_rsp.done |=> !s.req.valid)
        else $error("command started while busy");
    data_locked_a: assert property (@(posedge core_clk) disable iff (reset)
        s.dp_valid && s.dp_write && s.dp_addr == `DATA_OFFSET && s.busy && !eng_rsp.done
            |=> s.data == $past(s.data))
        else $error("data changed while busy");
    status_sticky_a: assert property (@(posedge core_clk) disable iff (reset)
        eng_rsp.done && !s.boot |=> s.istat[`IRQ_DONE_BIT])
        else $error("done event lost to a clear");

    // Main scenarios seen by the bench
    host_read_c: cover property (@(posedge core_clk) disable iff (reset)
        eng_rsp.done && !s.boot && s.op != `OP_WRITE);
    host_write_c: cover property (@(posedge core_clk) disable iff (reset)
        eng_rsp.done && !eng_rsp.timed_out && s.op == `OP_WRITE);
    timeout_c: cover property (@(posedge core_clk) disable iff (reset) eng_rsp.timed_out);
    boot_done_c: cover property (@(posedge core_clk) disable iff (reset) $fell(s.boot));
    refused_start_c: cover property (@(posedge core_clk) disable iff (reset) cmd_wr && s.busy);
endmodule // eeprom_command_control

// [tb/prom_model.sv]
// Behavioural serial EEPROM: 24-bit frames, one byte read or written.
// Assumes cs, sck and data from the controller; an empty socket is pulled low.
`timescale 1ns/1ps
module prom_model (
    input  wire logic        cs,
    input  wire logic        sck,
    input  wire logic        din,
    input  wire logic        present,
    input  wire logic [11:0] wr_delay,
    output logic             dout
);
    logic [7:0]  mem [256];
    logic [23:0] sh;
    logic [7:0]  ins;
    logic [7:0]  adr;
    logic        drive;
    int          cnt;
    // ****************************************
    // Frame handling
    // ****************************************
    initial begin
        drive = 1'b0;
        cnt = 0;
        for (int i = 0; i < 256; i++) mem[i] = {i[3:0], i[7:4]} ^ 8'h3C;
    end
    // Pull-down wins when no part is fitted
    assign dout = present ? drive : 1'b0;
    // Select edge restarts framing; a released line shows the inverted last bit
    always @(cs) begin
        cnt = 0;
        drive = ~drive;
    end
    // Shift in on rise; a finished write answers ready only after its write time
    always @(posedge sck) begin
        if (cs && cnt < 24) begin
            sh = {sh[22:0], din};
            cnt++;
            if (cnt == 24 && ins == 8'h02 && present) begin
                mem[adr] = sh[7:0];
                drive = 1'b0;
                #(wr_delay) if (cs) drive = 1'b1;
            end
        end
    end
    // Data out changes on fall; filler bits toggle so nothing looks stable
    always @(negedge sck) begin
        if (cs && cnt == 16) begin
            ins = sh[15:8];
            adr = sh[7:0];
        end
        if (cs && cnt >= 16 && cnt < 24 && ins == 8'h03) drive = mem[adr][23 - cnt];
        else if (cs && cnt < 24) drive = ~drive;
    end
endmodule // prom_model

// [tb/eeprom_command_control_tb_top.sv]
// Self-checking bench: AHB-Lite master, random and corner EEPROM operations.
// Assumes prom_consts.svh offsets and a behavioural EEPROM on the serial pins.
`timescale 1ns/1ps
`include "prom_consts.svh"
module eeprom_command_control_tb_top;
    localparam int TMO = 200;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h0;
    logic [2:0]  hsize    = 3'h2;
    logic        present  = 1'b1;
    logic [11:0] wr_delay = 12'h028;
    logic        hready, hreadyout, hresp, prom_cs, prom_sck, prom_do, prom_di, irq;
    logic [31:0] hrdata;
    logic [47:0] mac_addr;
    logic [7:0]  shadow [256];
    integer      seed = 32'hEA16FDC8;
    int          error_cnt = 0;
    int          checked = 0;
    // ****************************************
    // Instances and clock
    // ****************************************
    always #10 core_clk = ~core_clk;
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    // Input sampling trails the pin by two flops, so a half period under three reads stale bits
    eeprom_command_control #(.TIMEOUT_CYCLES(TMO), .SCK_HALF(4)) DUT (
        .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .prom_cs(prom_cs), .prom_sck(prom_sck),
        .prom_do(prom_do), .prom_di(prom_di), .mac_addr(mac_addr), .irq(irq));
    prom_model part (.cs(prom_cs), .sck(prom_sck), .din(prom_do), .present(present),
        .wr_delay(wr_delay), .dout(prom_di));
    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [7:0] fill(input logic [7:0] a);
        return {a[3:0], a[7:4]} ^ 8'h3C;
    endfunction
    task automatic final_report();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Read data is the pre-edge value at the edge that ends the data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= 2'b10;
        do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 50);
        rd = hrdata;
        if (n >= 50) begin error_cnt++; final_report(); end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    // Registers left alone while busy; poll is bounded
    task automatic wait_idle(output int n);
        logic [31:0] v;
        n = 0;
        do begin bus(1'b0, `CMD_OFFSET, 32'h0, v); n++; end
        while (v[31] !== 1'b0 && n < 2000);
        if (n >= 2000) begin error_cnt++; final_report(); end
    endtask
    task automatic run(input logic [2:0] op, input logic [7:0] a, input logic [7:0] d,
                       output int n);
        logic [31:0] v;
        if (op == `OP_WRITE) wr(`DATA_OFFSET, {24'h0, d});
        wr(`CMD_OFFSET, {1'b1, op, 20'h0, a});
        bus(1'b0, `CMD_OFFSET, 32'h0, v);
        chk("busy_set", 32'h1, {31'h0, v[31]});
        wait_idle(n);
        if (op == `OP_WRITE && present) shadow[a] = d;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (80000) @(posedge core_clk);
        error_cnt++;
        final_report();
    end
    initial begin
        logic [31:0] v;
        logic [7:0]  a;
        logic [2:0]  op;
        int          n;
        for (int i = 0; i < 256; i++) shadow[i] = fill(i[7:0]);
        for (int r = 0; r < 2; r++) begin
            repeat (4) @(posedge core_clk);
            reset <= 1'b0;
            @(posedge core_clk);
            bus(1'b0, `CMD_OFFSET, 32'h0, v);
            chk("boot_busy", 32'h1, {31'h0, v[31]});
            // Second boot: host writes during the load must be refused
            if (r == 1) begin
                wr(`DATA_OFFSET, 32'h0000005A);
                wr(`CMD_OFFSET, {1'b1, `OP_WRITE, 20'h0, 8'h21});
            end
            wait_idle(n);
            for (int i = 0; i < 6; i++) begin
                chk("mac", {24'h0, fill(i[7:0])}, {24'h0, mac_addr[8*i +: 8]});
            end
            if (r == 1) begin
                bus(1'b0, `CMD_OFFSET, 32'h0, v);
                chk("cmd_refused", 32'h0, v);
                bus(1'b0, `DATA_OFFSET, 32'h0, v);
                chk("data_refused", 32'h0, v);
            end
            if (r == 0) reset <= 1'b1;
        end
        wr(`ICLR_OFFSET, 32'h3);
        wr(`IEN_OFFSET, 32'h1);
        // Corners first: address ends and a write, then random codes; delays alternate between 40 and 1500
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            op = (i < 2) ? `OP_WRITE : 3'($random(seed));
            wr_delay <= (i % 2) ? 12'd1500 : 12'd40;
            run(op, a, 8'($random(seed)), n);
            run(3'h0, a, 8'h00, n);
            bus(1'b0, `DATA_OFFSET, 32'h0, v);
            chk("read_data", {24'h0, shadow[a]}, {24'h0, v[7:0]});
        end
        bus(1'b0, `ISTAT_OFFSET, 32'h0, v);
        chk("status_done", 32'h1, {30'h0, v[1:0]});
        chk("irq_on", 32'h1, {31'h0, irq});
        wr(`IEN_OFFSET, 32'h0);
        repeat (2) @(posedge core_clk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(`ICLR_OFFSET, 32'h3);
        bus(1'b0, `ISTAT_OFFSET, 32'h0, v);
        chk("status_clr", 32'h0, {30'h0, v[1:0]});
        // Zero in the busy bit must not start anything
        wr(`CMD_OFFSET, {1'b0, `OP_WRITE, 20'h0, 8'h12});
        repeat (4) @(posedge core_clk);
        chk("no_start", 32'h0, {31'h0, prom_cs});
        bus(1'b0, `CMD_OFFSET, 32'h0, v);
        chk("no_busy", 32'h0, {31'h0, v[31]});
        wr(8'hA0, 32'hFFFFFFFF);
        bus(1'b0, 8'hA0, 32'h0, v);
        chk("unmapped", 32'h0, v);
        // Empty socket: write waits out the time-out, then busy drops
        present <= 1'b0;
        wr(`IEN_OFFSET, 32'h2);
        run(`OP_WRITE, 8'h40, 8'h77, n);
        chk("tmo_len", 32'h1, {31'h0, n * 2 >= TMO});
        bus(1'b0, `CMD_OFFSET, 32'h0, v);
        chk("tmo_flag", 32'h1, {31'h0, v[`CMD_TMO_BIT]});
        bus(1'b0, `ISTAT_OFFSET, 32'h0, v);
        chk("tmo_status", 32'h1, {31'h0, v[1]});
        chk("tmo_irq", 32'h1, {31'h0, irq});
        chk("hresp", 32'h0, {31'h0, hresp});
        final_report();
    end
endmodule // eeprom_command_control_tb_top
